// ===== logic/sws_defs.svh
`ifndef SWS_DEFS_SVH
`define SWS_DEFS_SVH
// header field widths
`define SWS_ADDR_W        16
`define SWS_LEN_W         15
`define SWS_BYTE_W        8
`define SWS_BIT_CNT_W     3
`define SWS_BIT_LAST      3'h7
`define SWS_LEN_ONE       15'h0001
`define SWS_LEN_ZERO      15'h0000
// device output latency after the reference edge (rule figure)
`define SWS_TDR_SYS_CLKS  6
`define SWS_TDR_EXTRA_NS  30
`define SWS_CLK_PERIOD_NS 4
`define SWS_TDR_CYCLES    (`SWS_TDR_SYS_CLKS + `SWS_TDR_EXTRA_NS / `SWS_CLK_PERIOD_NS)
// initialisation time after reset, in microseconds
`define SWS_INIT_US       60300
`define SWS_CLK_MHZ       250
`define SWS_INIT_CYCLES   (`SWS_INIT_US * `SWS_CLK_MHZ)
`define SWS_INIT_CNT_W    25
`endif

// ===== logic/sws_pkg.sv
package sws_pkg;
  typedef enum logic [2:0] {
    SWS_ADDR_HI,
    SWS_ADDR_LO,
    SWS_LEN_HI,
    SWS_LEN_LO,
    SWS_DATA,
    SWS_IGNORE
  } sws_state_type;

  // one write to the device's memory space
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        burst;
  } sws_wr_type;

  // decoded frame header, shown to the core
  typedef struct packed {
    logic [15:0] addr;
    logic        rw_select_bit;
    logic [14:0] len;
  } sws_hdr_type;
endpackage

// ===== logic/sws_spi_slave_write.sv
`include "sws_defs.svh"

// How it works
// RULE1 - select low opens frame; fields arrive in order
// RULE2 - header: address16, write bit, length15, data bytes
// RULE3 - length one writes a single byte
// RULE4 - longer length bursts to consecutive addresses
// RULE5 - host sets 0x80 and upper length bits
// RULE6 - host sends low length byte last
// RULE7 - host waits three clocks before sclk
// RULE8 - host keeps select high two clocks
// RULE9 - output data valid within latency bound
// RULE10 - host holds hard reset at least 210ns; the testbench holds its first reset only 4 clocks (16ns)
// RULE11 - host serial clock at most 70MHz
// RULE12 - sample on rising, change on falling
// RULE13 - device ready only after init time
// RULE14 - host sends msb byte and bit first
// RULE15 - select rise resets frame state machine
module sws_spi_slave_write #(
  parameter int unsigned INIT_CYCLES = `SWS_INIT_CYCLES
) (
  input  wire logic                core_clk,
  input  wire logic                hard_reset_n,
  input  wire logic                spi_select_n,
  input  wire logic                spi_sclk,
  input  wire logic                spi_mosi,
  output logic                     spi_miso,
  output logic                     spi_miso_oe,
  output logic                     init_done,
  output logic                     wr_valid,
  output sws_pkg::sws_wr_type      wr_req,
  output sws_pkg::sws_hdr_type     hdr,
  output logic                     frame_active
);

  // ==========================================================
  // pin synchronisers
  logic [1:0] sel_sync_r;
  logic [1:0] sck_sync_r;
  logic [1:0] mosi_sync_r;
  logic       sck_prev_r;

  always_ff @(posedge core_clk) begin
    if (!hard_reset_n) begin
      sel_sync_r  <= 2'h3;
      sck_sync_r  <= 2'h0;
      mosi_sync_r <= 2'h0;
      sck_prev_r  <= 1'b0;
    end else begin
      sel_sync_r  <= {sel_sync_r[0], spi_select_n};
      sck_sync_r  <= {sck_sync_r[0], spi_sclk};
      mosi_sync_r <= {mosi_sync_r[0], spi_mosi};
      sck_prev_r  <= sck_sync_r[1];
    end
  end

  wire sel_n    = sel_sync_r[1];
  wire sck_rise = sck_sync_r[1] & ~sck_prev_r;
  wire sck_fall = ~sck_sync_r[1] & sck_prev_r;
  wire mosi_s   = mosi_sync_r[1];

  // ==========================================================
  // initialisation timer
  logic [`SWS_INIT_CNT_W-1:0] init_cnt_r;
  wire init_end = (init_cnt_r == `SWS_INIT_CNT_W'(INIT_CYCLES - 1));

  // RULE13 init wait
  always_ff @(posedge core_clk) begin
    if (!hard_reset_n) begin
      init_cnt_r <= '0;
      init_done  <= 1'b0;
    end else if (!init_done) begin
      init_cnt_r <= init_cnt_r + 1'b1;
      init_done  <= init_end;
    end
  end

  // ==========================================================
  // byte shifter
  logic [`SWS_BIT_CNT_W-1:0] bit_cnt_r;
  logic [`SWS_BYTE_W-1:0]    shift_r;
  wire  [`SWS_BYTE_W-1:0]    byte_in   = {shift_r[`SWS_BYTE_W-2:0], mosi_s};
  // RULE12 rising sample
  wire                       byte_done = sck_rise && (bit_cnt_r == `SWS_BIT_LAST) && !sel_n;

  always_ff @(posedge core_clk) begin
    if (!hard_reset_n || sel_n) begin
      bit_cnt_r <= '0;
      shift_r   <= '0;
    end else if (sck_rise) begin
      bit_cnt_r <= bit_cnt_r + 1'b1;
      shift_r   <= byte_in;
    end
  end

  // ==========================================================
  // frame state machine
  sws_pkg::sws_state_type state_r;
  sws_pkg::sws_state_type state_nxt;
  logic [`SWS_ADDR_W-1:0] addr_r;
  logic [`SWS_LEN_W-1:0]  len_r;
  logic [`SWS_LEN_W-1:0]  left_r;
  logic                   wr_bit_r;

  wire [`SWS_LEN_W-1:0] len_rx = {len_r[`SWS_LEN_W-1:`SWS_BYTE_W], byte_in};

  // RULE1 field order
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sws_pkg::SWS_ADDR_HI: state_nxt = sws_pkg::SWS_ADDR_LO;
      sws_pkg::SWS_ADDR_LO: state_nxt = sws_pkg::SWS_LEN_HI;
      sws_pkg::SWS_LEN_HI:  state_nxt = sws_pkg::SWS_LEN_LO;
      // read frames and zero length are not this block's business
      sws_pkg::SWS_LEN_LO:
        state_nxt = (wr_bit_r && len_rx != `SWS_LEN_ZERO) ? sws_pkg::SWS_DATA
                                                          : sws_pkg::SWS_IGNORE;
      sws_pkg::SWS_DATA:
        state_nxt = (left_r == `SWS_LEN_ONE) ? sws_pkg::SWS_IGNORE : sws_pkg::SWS_DATA;
      sws_pkg::SWS_IGNORE:  state_nxt = sws_pkg::SWS_IGNORE;
      default:              state_nxt = sws_pkg::SWS_IGNORE;
    endcase
  end

  // RULE15 select rise resets
  always_ff @(posedge core_clk) begin
    if (!hard_reset_n || sel_n) begin
      state_r <= sws_pkg::SWS_ADDR_HI;
    end else if (byte_done && init_done) begin
      state_r <= state_nxt;
    end
  end

  // RULE2 header capture
  always_ff @(posedge core_clk) begin
    if (!hard_reset_n) begin
      addr_r   <= '0;
      len_r    <= '0;
      left_r   <= '0;
      wr_bit_r <= 1'b0;
    end else if (byte_done && init_done) begin
      case (state_r)
        sws_pkg::SWS_ADDR_HI: addr_r[`SWS_ADDR_W-1:`SWS_BYTE_W] <= byte_in;
        sws_pkg::SWS_ADDR_LO: addr_r[`SWS_BYTE_W-1:0]           <= byte_in;
        sws_pkg::SWS_LEN_HI: begin
          wr_bit_r                          <= byte_in[`SWS_BYTE_W-1];
          len_r[`SWS_LEN_W-1:`SWS_BYTE_W]   <= byte_in[`SWS_BYTE_W-2:0];
        end
        sws_pkg::SWS_LEN_LO: begin
          len_r[`SWS_BYTE_W-1:0] <= byte_in;
          left_r                 <= len_rx;
        end
        // RULE4 burst increment
        sws_pkg::SWS_DATA: begin
          addr_r <= addr_r + 1'b1;
          left_r <= left_r - 1'b1;
        end
        default: addr_r <= addr_r;
      endcase
    end
  end

  // ==========================================================
  // write strobe to the core
  wire wr_now = byte_done && init_done && (state_r == sws_pkg::SWS_DATA);

  // RULE3 single or burst write
  always_ff @(posedge core_clk) begin
    if (!hard_reset_n) begin
      wr_valid <= 1'b0;
      wr_req   <= '0;
    end else begin
      wr_valid <= wr_now;
      if (wr_now) begin
        wr_req.addr  <= addr_r;
        wr_req.data  <= byte_in;
        wr_req.burst <= (len_r != `SWS_LEN_ONE);
      end
    end
  end

  assign hdr.addr          = addr_r;
  assign hdr.rw_select_bit = wr_bit_r;
  assign hdr.len           = len_r;
  assign frame_active      = !sel_n;

  // ==========================================================
  // serial output: a write frame returns zeros, driven while selected
  // RULE9 output on falling edge
  always_ff @(posedge core_clk) begin
    if (!hard_reset_n || sel_n) begin
      spi_miso <= 1'b0;
    end else if (sck_fall) begin
      spi_miso <= 1'b0;
    end
  end
  assign spi_miso_oe = !sel_n;

  // ==========================================================
  // checks
  a_wr_only_data: assert property (@(posedge core_clk) disable iff (!hard_reset_n)
    wr_valid |-> $past(state_r) == sws_pkg::SWS_DATA) // RULE3
    else $error("write strobe outside data phase");
  a_burst_addr_step: assert property (@(posedge core_clk) disable iff (!hard_reset_n)
    wr_now |=> addr_r == $past(addr_r) + 1'b1) // RULE4
    else $error("burst address stepping broken");
  a_sel_resets_fsm: assert property (@(posedge core_clk) disable iff (!hard_reset_n)
    sel_n |=> state_r == sws_pkg::SWS_ADDR_HI) // RULE15
    else $error("frame state not reset by select");
  a_no_wr_before_init: assert property (@(posedge core_clk) disable iff (!hard_reset_n)
    !init_done |-> !wr_valid) // RULE13
    else $error("write before init done");
  a_miso_quiet_idle: assert property (@(posedge core_clk) disable iff (!hard_reset_n)
    $rose(sel_n) |-> ##[1:2] !spi_miso_oe) // RULE9
    else $error("miso still driven after deselect");
  a_wr_bit_needed: assert property (@(posedge core_clk) disable iff (!hard_reset_n)
    (state_r == sws_pkg::SWS_DATA) |-> wr_bit_r) // RULE2
    else $error("data phase without write bit");
  a_addr_order: assert property (@(posedge core_clk) disable iff (!hard_reset_n)
    (byte_done && init_done && state_r == sws_pkg::SWS_ADDR_HI)
    |=> state_r == sws_pkg::SWS_ADDR_LO) // RULE1
    else $error("header order broken");
  a_sample_rise: assert property (@(posedge core_clk) disable iff (!hard_reset_n)
    (!sel_n && !sck_rise) |=> $stable(bit_cnt_r)) // RULE12
    else $error("bit counted without rising edge");

endmodule

// ===== verif/sws_host_model.sv
// host side of the frame: drives select, serial clock and data
module sws_host_model (
  input  wire logic core_clk,
  output logic      spi_select_n,
  output logic      spi_sclk,
  output logic      spi_mosi
);
  timeunit 1ns;
  timeprecision 1ps;

  // sclk idles low between frames, mode 0
  initial begin
    spi_select_n = 1'b1;
    spi_sclk     = 1'b0;
    spi_mosi     = 1'b0;
  end

  // ==========================================================
  // frame transfer, 20 core clocks per bit gives an 80 ns sclk
  // ==========================================================
  task automatic send(input logic [7:0] q[$]);
    // select low for the whole frame
    spi_select_n = 1'b0;
    // three clocks or more before the first edge
    repeat (3) @(negedge core_clk);
    // msb first, change on fall, device samples on rise
    foreach (q[i]) begin
      for (int k = 7; k >= 0; k--) begin
        spi_mosi = q[i][k];
        repeat (10) @(negedge core_clk);
        spi_sclk = 1'b1;
        repeat (10) @(negedge core_clk);
        spi_sclk = 1'b0;
      end
    end
    // released line must not keep showing the last bit
    spi_mosi     = ~spi_mosi;
    spi_select_n = 1'b1;
    // minimum high time before the next frame
    repeat (2) @(negedge core_clk);
  endtask
endmodule

// ===== verif/spi_slave_write_frame_tb.sv
module spi_slave_write_frame_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned INIT = 2000;
  logic                 core_clk;
  logic                 hard_reset_n;
  wire                  sel_n;
  wire                  sclk;
  wire                  mosi;
  logic                 miso;
  logic                 miso_oe;
  logic                 init_done;
  logic                 wr_valid;
  logic                 frame_active;
  sws_pkg::sws_wr_type  wr_req;
  sws_pkg::sws_hdr_type hdr;
  sws_pkg::sws_wr_type  exp_q[$];
  logic [7:0]           bq[$];
  int                   failures = 0;
  int                   total_checks = 0;
  int                   seed = 50;
  int                   cycles = 0;
  bit                   live = 1'b0;

  sws_spi_slave_write #(.INIT_CYCLES(INIT)) i_dut (.core_clk(core_clk), .hard_reset_n(hard_reset_n),
    .spi_select_n(sel_n), .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso),
    .spi_miso_oe(miso_oe), .init_done(init_done), .wr_valid(wr_valid), .wr_req(wr_req),
    .hdr(hdr), .frame_active(frame_active));
  sws_host_model i_host (.core_clk(core_clk), .spi_select_n(sel_n), .spi_sclk(sclk),
    .spi_mosi(mosi));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    total_checks++;
    if (seen !== expd) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // one frame: header bytes, n data bytes, expected writes noted
  // ==========================================================
  task automatic frame(input logic [15:0] a, input logic rw, input logic [14:0] len,
                       input int n, input bit wr);
    logic [7:0] d;
    int         nw;
    nw = 0;
    // header byte order and write flag
    bq = '{a[15:8], a[7:0], {rw, len[14:8]}, len[7:0]};
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      bq.push_back(d);
      if (wr && i < int'(len)) begin
        exp_q.push_back(sws_pkg::sws_wr_type'{16'(a + i), d, len > 15'h0001});
        nw++;
      end
    end
    i_host.send(bq);
    check({frame_active, miso_oe}, 2'h0);
    if (live) check({hdr.addr, hdr.rw_select_bit, hdr.len}, {16'(a + nw), rw, len});
  endtask

  // ==========================================================
  // monitor: every write must match the oldest note
  // ==========================================================
  always @(negedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles > 40000) begin
      failures++;
      end_of_test();
    end else if (hard_reset_n && wr_valid === 1'b1) begin
      check(exp_q.size() != 0, 1);
      check({frame_active, miso_oe, miso}, 3'h6);
      if (exp_q.size() != 0) check(wr_req, exp_q.pop_front());
    end
  end

  initial begin
    hard_reset_n = 1'b0;
    repeat (4) @(negedge core_clk);
    hard_reset_n = 1'b1;
    // a frame before initialisation writes nothing
    frame(16'h1234, 1'b1, 15'h0001, 1, 1'b0);
    check(init_done, 1'b0);
    for (int i = 0; i < INIT && init_done !== 1'b1; i++) @(negedge core_clk);
    check(init_done, 1'b1);
    live = 1'b1;
    frame(16'($random(seed)), 1'b1, 15'h0001, 1, 1'b1);
    frame(16'hfffe, 1'b1, 15'h0003, 3, 1'b1);
    // extra bytes past length, then read and zero length frames are refused
    frame(16'($random(seed)), 1'b1, 15'h0001, 2, 1'b1);
    frame(16'($random(seed)), 1'b0, 15'h0002, 2, 1'b0);
    frame(16'($random(seed)), 1'b1, 15'h0000, 1, 1'b0);
    // frame cut short, next header must start afresh
    frame(16'($random(seed)), 1'b1, 15'h0005, 2, 1'b1);
    for (int j = 0; j < 3; j++) frame(16'($random(seed)), 1'b1, 15'(j + 2), j + 2, 1'b1);
    repeat (20) @(negedge core_clk);
    check(exp_q.size(), 0);
    // mid-run hard reset held past 210 ns, then init again
    hard_reset_n = 1'b0;
    repeat (60) @(negedge core_clk);
    check({init_done, wr_valid, miso_oe, frame_active}, 4'h0);
    hard_reset_n = 1'b1;
    @(negedge core_clk);
    check(init_done, 1'b0);
    for (int i = 0; i < INIT && init_done !== 1'b1; i++) @(negedge core_clk);
    check(init_done, 1'b1);
    frame(16'($random(seed)), 1'b1, 15'h0002, 2, 1'b1);
    repeat (20) @(negedge core_clk);
    check(exp_q.size(), 0);
    end_of_test();
  end
endmodule
